// ===== core/cgr_global_regs.v
// global clock select, reset and loopback registers of the quad codec
`include "cgr_consts.vh"

module cgr_global_regs #(
  parameter DET_WINDOW_CYC = `CGR_DET_WINDOW_CYC,
  // arbitrary neutral version value
  parameter [7:0] VERSION_CODE = 8'h31
) (
  input wire core_clk,
  input wire srst,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  output reg rd_valid,
  output reg [7:0] rd_data,
  input wire interface_mode_pin,
  input wire interface_data_clock,
  input wire local_cmd_valid,
  output wire [3:0] local_cmd_strobe,
  output reg [3:0] mclk_freq_code,
  output reg hard_reset_request,
  output reg [3:0] soft_reset_request,
  output reg analog_loop_64k,
  output reg analog_loop_8k,
  output reg analog_loop_tx_to_rx,
  output reg digital_loop_64k,
  output reg digital_loop_8k,
  output reg digital_loop_tx_to_rx
);

  localparam ST_IDLE = 1'b0;
  localparam ST_DATA = 1'b1;
  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_CLK = 2'h1;
  localparam [1:0] SEL_RST = 2'h2;
  localparam [1:0] SEL_LOOP = 2'h3;
  // window length cut to the counter width on purpose
  localparam integer WIN_LAST_INT = DET_WINDOW_CYC - 1;
  localparam [16:0] WIN_LAST = WIN_LAST_INT[16:0];

  function [1:0] reg_select;
    input [6:0] addr;
    begin
      case (addr)
        `CGR_ADDR_CLK_EN: reg_select = SEL_CLK;
        `CGR_ADDR_RESET: reg_select = SEL_RST;
        `CGR_ADDR_LOOP: reg_select = SEL_LOOP;
        default: reg_select = SEL_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg [2:0] mode_sync_reg;
  reg [2:0] dcl_sync_reg;
  reg interface_mode_reg;
  wire port_mode;
  wire dcl_rise;

  always @(posedge core_clk) begin
    mode_sync_reg <= {mode_sync_reg[1:0], interface_mode_pin};
    dcl_sync_reg <= {dcl_sync_reg[1:0], interface_data_clock};
  end

  always @(posedge core_clk) begin
    if (srst) begin
      interface_mode_reg <= 1'b0;
    end else if (mode_sync_reg[2] == mode_sync_reg[1]) begin
      interface_mode_reg <= mode_sync_reg[2];
    end
  end

  assign port_mode = ~interface_mode_reg;
  assign dcl_rise = dcl_sync_reg[1] & ~dcl_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // data clock rate detection for interface mode

  reg [16:0] win_cnt_reg;
  reg [9:0] edge_cnt_reg;
  reg dcl_fast_reg;

  always @(posedge core_clk) begin
    if (srst) begin
      win_cnt_reg <= 17'h00000;
      edge_cnt_reg <= 10'h000;
      dcl_fast_reg <= 1'b0;
    end else if (win_cnt_reg == WIN_LAST) begin
      win_cnt_reg <= 17'h00000;
      edge_cnt_reg <= 10'h000;
      dcl_fast_reg <= (edge_cnt_reg >= `CGR_DET_THRESHOLD);
    end else begin
      win_cnt_reg <= win_cnt_reg + 17'h00001;
      if (dcl_rise && edge_cnt_reg != 10'h3ff) begin
        edge_cnt_reg <= edge_cnt_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command byte decoder and register file

  reg state_reg;
  reg [1:0] target_reg;
  reg [3:0] chan_enable_reg;
  reg [3:0] mclk_sel_reg;
  reg [7:0] loop_reg;
  wire int_reset;
  wire cmd_write;
  wire [1:0] cmd_sel;

  // internal hardware reset acts like the reset pin, except the mode filter and rate detector clear on srst only
  assign int_reset = srst | hard_reset_request;
  assign cmd_write = cmd_byte[`CGR_CMD_WRITE_BIT];
  assign cmd_sel = reg_select(cmd_byte[`CGR_CMD_ADDR_MSB:0]);

  always @(posedge core_clk) begin
    if (int_reset) begin
      state_reg <= ST_IDLE;
      target_reg <= SEL_NONE;
      chan_enable_reg <= `CGR_CHEN_RESET;
      mclk_sel_reg <= `CGR_MCLK_RESET;
      loop_reg <= `CGR_LOOP_RESET;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      hard_reset_request <= 1'b0;
      soft_reset_request <= 4'h0;
    end else begin
      rd_valid <= 1'b0;
      hard_reset_request <= 1'b0;
      soft_reset_request <= 4'h0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid && cmd_sel != SEL_NONE) begin
            if (cmd_write) begin
              state_reg <= ST_DATA;
              target_reg <= cmd_sel;
            end else begin
              rd_valid <= 1'b1;
              case (cmd_sel)
                SEL_CLK: rd_data <= {chan_enable_reg, mclk_sel_reg};
                SEL_RST: rd_data <= VERSION_CODE;
                default: rd_data <= loop_reg;
              endcase
            end
          end
        end
        ST_DATA: begin
          if (cmd_valid) begin
            state_reg <= ST_IDLE;
            case (target_reg)
              SEL_CLK: begin
                chan_enable_reg <= cmd_byte[`CGR_CHEN_MSB:`CGR_CHEN_LSB];
                mclk_sel_reg <= cmd_byte[`CGR_MCLK_MSB:`CGR_MCLK_LSB];
              end
              SEL_RST: begin
                hard_reset_request <= cmd_byte[`CGR_HARD_RESET_REQUEST_BIT];
                if (cmd_byte[`CGR_SOFT_RESET_REQUEST_BIT]) begin
                  soft_reset_request <= cmd_byte[`CGR_RCH_MSB:`CGR_RCH_LSB];
                end
              end
              SEL_LOOP: loop_reg <= cmd_byte & `CGR_LOOP_MASK;
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // effective controls

  // enables gate channel commands only in port mode
  assign local_cmd_strobe = {4{local_cmd_valid}} & (port_mode ? chan_enable_reg : 4'hf);

  always @(posedge core_clk) begin
    if (int_reset) begin
      mclk_freq_code <= `CGR_MCLK_RESET;
      analog_loop_64k <= 1'b0;
      analog_loop_8k <= 1'b0;
      analog_loop_tx_to_rx <= 1'b0;
      digital_loop_64k <= 1'b0;
      digital_loop_8k <= 1'b0;
      digital_loop_tx_to_rx <= 1'b0;
    end else begin
      if (port_mode) begin
        mclk_freq_code <= mclk_sel_reg;
      end else begin
        mclk_freq_code <= dcl_fast_reg ? `CGR_MCLK_4096 : `CGR_MCLK_2048;
      end
      analog_loop_64k <= loop_reg[`CGR_ANALOG_LOOP_64K_BIT];
      analog_loop_8k <= loop_reg[`CGR_ANALOG_LOOP_8K_BIT];
      analog_loop_tx_to_rx <= loop_reg[`CGR_ANALOG_LOOP_TX_TO_RX_BIT] & port_mode;
      digital_loop_64k <= loop_reg[`CGR_DIGITAL_LOOP_64K_BIT];
      digital_loop_8k <= loop_reg[`CGR_DIGITAL_LOOP_8K_BIT];
      digital_loop_tx_to_rx <= loop_reg[`CGR_DIGITAL_LOOP_TX_TO_RX_BIT] & port_mode;
    end
  end

endmodule

// ===== core/cgr_consts.vh
// constants for the codec global clock, reset and loopback registers
// Functional notes
// - clock/enable register: read 23H, write A3H
// - per-channel commands reach only enabled channels in port mode; all channels in interface mode
// - enable bit n is channel n+1, default off
// - nine clock select codes, 2.048 MHz default
// - port mode only; interface mode detects data clock
// - reset register: write A4H, read 24H
// - bit 7 write makes a hardware reset
// - bit 5 resets selected channels' local registers
// - select bits 3..0 pick channels 4..1
// - reset register reads a fixed version code
// - loopback register: read 25H, write A5H
// - analog 64k loop bit, default normal
// - tx-to-rx loops only in port mode
// - other loop bits default off, 1 enables
`ifndef CGR_CONSTS_VH
`define CGR_CONSTS_VH

// command byte layout
`define CGR_CMD_WRITE_BIT 7
`define CGR_CMD_ADDR_MSB 6
`define CGR_ADDR_CLK_EN 7'h23
`define CGR_ADDR_RESET 7'h24
`define CGR_ADDR_LOOP 7'h25

// clock and channel enable register fields
`define CGR_CHEN_MSB 7
`define CGR_CHEN_LSB 4
`define CGR_MCLK_MSB 3
`define CGR_MCLK_LSB 0
`define CGR_CHEN_RESET 4'h0
`define CGR_MCLK_RESET 4'h2

// master clock select codes
`define CGR_MCLK_8192 4'h0
`define CGR_MCLK_4096 4'h1
`define CGR_MCLK_2048 4'h2
`define CGR_MCLK_1536 4'h6
`define CGR_MCLK_1544 4'he
`define CGR_MCLK_3072 4'h5
`define CGR_MCLK_3088 4'hd
`define CGR_MCLK_6144 4'h4
`define CGR_MCLK_6176 4'hc

// reset register fields
`define CGR_HARD_RESET_REQUEST_BIT 7
`define CGR_SOFT_RESET_REQUEST_BIT 5
`define CGR_RCH_MSB 3
`define CGR_RCH_LSB 0

// loopback register fields
`define CGR_ANALOG_LOOP_64K_BIT 6
`define CGR_ANALOG_LOOP_8K_BIT 5
`define CGR_ANALOG_LOOP_TX_TO_RX_BIT 4
`define CGR_DIGITAL_LOOP_64K_BIT 2
`define CGR_DIGITAL_LOOP_8K_BIT 1
`define CGR_DIGITAL_LOOP_TX_TO_RX_BIT 0
`define CGR_LOOP_MASK 8'h77
`define CGR_LOOP_RESET 8'h00

// data clock detection
`define CGR_CLK_PERIOD_NS 20
`define CGR_DET_WINDOW_NS 125000
`define CGR_DET_WINDOW_CYC (`CGR_DET_WINDOW_NS / `CGR_CLK_PERIOD_NS)
// edges per window: 256 at 2.048 MHz, 512 at 4.096 MHz
`define CGR_DET_THRESHOLD 10'h180

`endif

// ===== verif/cgr_host_model.sv
// host model that issues command bytes
module cgr_host_model (
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic core_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
  end
  // one byte per call; bus inverted once released
  task send(input logic [7:0] b);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask
endmodule

// ===== verif/cgr_global_regs_asserts.sv
// checker for the global register block
module cgr_global_regs_asserts #(
  parameter [7:0] VERSION_CODE = 8'h00
) (
  input wire core_clk,
  input wire srst,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  input wire rd_valid,
  input wire [7:0] rd_data,
  input wire interface_mode_pin,
  input wire local_cmd_valid,
  input wire [3:0] local_cmd_strobe,
  input wire [3:0] mclk_freq_code,
  input wire hard_reset_request,
  input wire [3:0] soft_reset_request,
  input wire analog_loop_64k,
  input wire digital_loop_8k,
  input wire analog_loop_tx_to_rx,
  input wire digital_loop_tx_to_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  reg pend_reg = 1'b0;
  reg [6:0] addr_reg = 7'h00;
  wire idle_cmd = cmd_valid && !pend_reg;
  wire hit = cmd_byte[6:0] >= 7'h23 && cmd_byte[6:0] <= 7'h25;
  // tracks whether the next byte is write data
  always @(posedge core_clk) begin
    if (srst || hard_reset_request)
      pend_reg <= 1'b0;
    else if (cmd_valid)
      pend_reg <= !pend_reg && cmd_byte[7] && hit;
    if (idle_cmd)
      addr_reg <= cmd_byte[6:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_wr(a);
    cmd_valid && pend_reg && addr_reg == a;
  endsequence
  a_read_answer: assert property (idle_cmd && cmd_byte == 8'h23 |=> rd_valid) else $error("no answer");
  a_rd_version: assert property (idle_cmd && cmd_byte == 8'h24 |=> rd_valid && rd_data == VERSION_CODE)
    else $error("bad version");
  a_rd_cause: assert property (rd_valid |-> $past(idle_cmd && !cmd_byte[7] && hit)) else $error("stray answer");
  a_hard_pulse: assert property (s_wr(7'h24) |=> hard_reset_request == $past(cmd_byte[7]) ##1 !hard_reset_request)
    else $error("bad hard reset");
  a_soft_pulse: assert property (s_wr(7'h24) |=> soft_reset_request == ($past(cmd_byte[5]) ? $past(cmd_byte[3:0]) : 4'h0)
    ##1 soft_reset_request == 4'h0) else $error("bad soft reset");
  a_loop_level: assert property (s_wr(7'h25) |=> ##1 analog_loop_64k == $past(cmd_byte[6], 2)
    && digital_loop_8k == $past(cmd_byte[1], 2)) else $error("bad loop level");
  a_mclk_code: assert property (s_wr(7'h23) ##0 !interface_mode_pin |=> ##1 mclk_freq_code == $past(cmd_byte[3:0], 2))
    else $error("bad clock code");
  a_strobe_idle: assert property (!local_cmd_valid |-> local_cmd_strobe == 4'h0) else $error("stray strobe");
  a_txrx_port: assert property (interface_mode_pin [*6] |-> !analog_loop_tx_to_rx && !digital_loop_tx_to_rx)
    else $error("loop in interface mode");
endmodule

// ===== verif/codec_global_clock_reset_loop_regs_tb.sv
// self-checking bench for the global register block
module codec_global_clock_reset_loop_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] VER = 8'h4c; // arbitrary neutral value
  logic core_clk = 1'b0, srst = 1'b1, mode = 1'b0, dclk = 1'b0, dclk_on = 1'b0, lcv = 1'b0;
  wire cmd_valid, rd_valid, hrr, a64, a8, atr, d64, d8, dtr;
  wire [7:0] cmd_byte, rd_data;
  wire [3:0] strobe, mclk, srr;
  int err_total = 0, checks_done = 0, i, dhalf = 122;
  logic [7:0] lfsr = 8'h3e, v;
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'he, 4'h5, 4'hd, 4'h4, 4'hc};
  initial forever #10 core_clk = ~core_clk;
  always #(dhalf) if (dclk_on) dclk = ~dclk;
  cgr_host_model host_u (.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .core_clk(core_clk));
  cgr_global_regs #(.VERSION_CODE(VER)) dut_u (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .rd_valid(rd_valid), .rd_data(rd_data), .interface_mode_pin(mode),
    .interface_data_clock(dclk), .local_cmd_valid(lcv), .local_cmd_strobe(strobe), .mclk_freq_code(mclk),
    .hard_reset_request(hrr), .soft_reset_request(srr), .analog_loop_64k(a64), .analog_loop_8k(a8),
    .analog_loop_tx_to_rx(atr), .digital_loop_64k(d64), .digital_loop_8k(d8), .digital_loop_tx_to_rx(dtr));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] loop_exp(input logic [7:0] d);
    return d & 8'h77;
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host_u.send(a);
    host_u.send(d);
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    host_u.send(a);
    #1;
    chk((rd_valid === 1'b1) ? rd_data : 8'hxx, exp, what);
  endtask
  task rst_wr(input logic [7:0] d);
    host_u.send(8'ha4);
    host_u.send(d);
    #1;
    chk({hrr, 3'h0, srr}, {d[7], 3'h0, d[5] ? d[3:0] : 4'h0}, "reset pulse");
  endtask
  task conclude;
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h23, 8'h02, "clk reset");
    rd(8'h25, 8'h00, "loop reset");
    for (i = 0; i < 9; i++) begin
      lfsr = nxt(lfsr);
      @(posedge core_clk);
      lcv <= lfsr[7];
      v = {lfsr[3:0], codes[i]};
      wr(8'ha3, v);
      rd(8'h23, v, "clk reg");
      chk({4'h0, mclk}, {4'h0, v[3:0]}, "mclk");
      chk({4'h0, strobe}, {4'h0, lfsr[7] ? v[7:4] : 4'h0}, "strobe");
      lfsr = nxt(lfsr);
      wr(8'ha5, lfsr);
      rd(8'h25, loop_exp(lfsr), "loop reg");
      chk({1'b0, a64, a8, atr, 1'b0, d64, d8, dtr}, loop_exp(lfsr), "loops");
      rd(8'h26 + i, 8'hxx, "unmapped");
    end
    rst_wr(8'h2a);
    rd(8'h23, v, "kept");
    rd(8'h24, VER, "version");
    wr(8'ha5, 8'h11);
    @(posedge core_clk);
    mode <= 1'b1;
    dclk_on <= 1'b1;
    for (i = 0; i < 15000 && mclk !== 4'h1; i++) @(posedge core_clk);
    chk({4'h0, mclk}, 8'h01, "detect");
    if (i == 15000) conclude;
    chk({6'h0, atr, dtr}, 8'h00, "tx loops");
    dhalf = 244;
    for (i = 0; i < 15000 && mclk !== 4'h2; i++) @(posedge core_clk);
    chk({4'h0, mclk}, 8'h02, "detect slow");
    if (i == 15000) conclude;
    @(posedge core_clk);
    mode <= 1'b0;
    dclk_on <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_wr(8'hff);
    @(posedge core_clk);
    #1;
    chk({hrr, 3'h0, srr}, 8'h00, "pulse end");
    rd(8'h23, 8'h02, "after hard");
    rd(8'h25, 8'h00, "loop after hard");
    conclude;
  end
endmodule
bind cgr_global_regs cgr_global_regs_asserts #(.VERSION_CODE(VERSION_CODE)) chk_u (.core_clk(core_clk), .srst(srst),
  .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .rd_valid(rd_valid), .rd_data(rd_data),
  .interface_mode_pin(interface_mode_pin), .local_cmd_valid(local_cmd_valid), .local_cmd_strobe(local_cmd_strobe),
  .mclk_freq_code(mclk_freq_code), .hard_reset_request(hard_reset_request), .soft_reset_request(soft_reset_request),
  .analog_loop_64k(analog_loop_64k), .digital_loop_8k(digital_loop_8k),
  .analog_loop_tx_to_rx(analog_loop_tx_to_rx), .digital_loop_tx_to_rx(digital_loop_tx_to_rx));
